/* design/dlom_mixer.sv */
// dual loop output mixer with axi4-lite registers
`timescale 1ns/1ps
module dlom_mixer #(
    parameter int W             = 32,
    parameter int UPDATE_CYCLES = dlom_pkg::UPDATE_CYCLES
) (
    input  wire logic                clk,
    input  wire logic                rst,
    input  wire logic [7:0]          s_axi_awaddr,
    input  wire logic                s_axi_awvalid,
    output logic                     s_axi_awready,
    input  wire logic [31:0]         s_axi_wdata,
    input  wire logic [3:0]          s_axi_wstrb,
    input  wire logic                s_axi_wvalid,
    output logic                     s_axi_wready,
    output logic [1:0]               s_axi_bresp,
    output logic                     s_axi_bvalid,
    input  wire logic                s_axi_bready,
    input  wire logic [7:0]          s_axi_araddr,
    input  wire logic                s_axi_arvalid,
    output logic                     s_axi_arready,
    output logic [31:0]              s_axi_rdata,
    output logic [1:0]               s_axi_rresp,
    output logic                     s_axi_rvalid,
    input  wire logic                s_axi_rready,
    input  wire logic signed [W-1:0] left_pos,
    input  wire logic signed [W-1:0] right_pos,
    input  wire logic signed [W-1:0] left_vel,
    input  wire logic signed [W-1:0] right_vel,
    input  wire logic signed [W-1:0] remote_heading,
    output logic signed [10:0]       motor_out,
    output logic signed [10:0]       follow_aux_difference,
    output logic                     out_strobe
);
    typedef enum logic [1:0] {UPD_IDLE, UPD_CALC, UPD_MIX} dlom_upd_type;

    dlom_upd_type       upd_state_reg;
    logic [31:0]        tick_cnt_reg;
    logic [31:0]        ctrl_reg;
    logic signed [W-1:0] pri_cmd_reg, aux_cmd_reg, pri_tgt_reg, aux_tgt_reg;
    logic signed [15:0] offset_stage_reg;
    logic signed [10:0] cmd_offset_reg;
    logic [15:0]        gain_reg;
    logic [1:0]         sticky_reg;
    logic               aw_held_reg, w_held_reg;
    logic [7:0]         awaddr_reg;
    logic [31:0]        wdata_reg;
    logic [3:0]         wstrb_reg;
    logic               wr_do, rd_do, tick;
    logic [2:0]         mode;
    logic               aux_active, offset_blocked, pri_write, clamp_hit;
    logic signed [10:0] offset_clamped, pri_term, aux_term, pct_term, pri_use, off_eff;
    logic signed [12:0] aux_eff, motor_sum, follow_sum;
    logic signed [W:0]  pos_sum, vel_sum, pri_fb_raw, aux_fb;
    logic signed [W+1:0] pri_fb, aux_fb_x, pri_tgt_x, aux_tgt_x;
    logic [1:0]         sticky_next;
    logic [31:0]        rd_word;
    logic               rd_ok;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[8*i +: 8] = nw[8*i +: 8];
            end
        end
        return res;
    endfunction

    function automatic logic signed [W-1:0] smooth(input logic signed [W-1:0] cur, input logic signed [W-1:0] cmd);
        logic signed [W:0] d;
        logic signed [W:0] step;
        d    = {cmd[W-1], cmd} - {cur[W-1], cur};
        step = d >>> dlom_pkg::SMOOTH_SHIFT;
        if (step == '0) begin
            return cmd;
        end
        return cur + step[W-1:0];
    endfunction

    function automatic logic signed [10:0] sat13(input logic signed [12:0] v);
        if (v > 13'sh03ff) begin
            return dlom_pkg::FULL_OUT;
        end else if (v < -13'sh03ff) begin
            return -dlom_pkg::FULL_OUT;
        end
        return v[10:0];
    endfunction

    // register bus: write address and data taken in either order
    assign wr_do = aw_held_reg && w_held_reg && !s_axi_bvalid;
    assign rd_do = s_axi_arvalid && s_axi_arready;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_axi_awready <= 1'b0;
            aw_held_reg   <= 1'b0;
            awaddr_reg    <= 8'h00;
        end else if (s_axi_awvalid && s_axi_awready) begin
            s_axi_awready <= 1'b0;
            aw_held_reg   <= 1'b1;
            awaddr_reg    <= s_axi_awaddr;
        end else begin
            if (wr_do) begin
                aw_held_reg <= 1'b0;
            end
            if (!aw_held_reg && !s_axi_bvalid) begin
                s_axi_awready <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_axi_wready <= 1'b0;
            w_held_reg   <= 1'b0;
            wdata_reg    <= 32'h0000_0000;
            wstrb_reg    <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            s_axi_wready <= 1'b0;
            w_held_reg   <= 1'b1;
            wdata_reg    <= s_axi_wdata;
            wstrb_reg    <= s_axi_wstrb;
        end else begin
            if (wr_do) begin
                w_held_reg <= 1'b0;
            end
            if (!w_held_reg && !s_axi_bvalid) begin
                s_axi_wready <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= dlom_pkg::RESP_OKAY;
        end else if (wr_do) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (awaddr_reg <= dlom_pkg::ADDR_STATUS && awaddr_reg[1:0] == 2'h0)
                            ? dlom_pkg::RESP_OKAY : dlom_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // control and gain registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl_reg <= dlom_pkg::CTRL_RESET;
            gain_reg <= dlom_pkg::GAIN_RESET;
        end else if (wr_do && awaddr_reg == dlom_pkg::ADDR_CTRL) begin
            ctrl_reg <= merge(ctrl_reg, wdata_reg, wstrb_reg) & 32'h0000_007f;
        end else if (wr_do && awaddr_reg == dlom_pkg::ADDR_GAIN) begin
            gain_reg <= 16'(merge({16'h0000, gain_reg}, wdata_reg, wstrb_reg));
        end
    end

    assign mode       = ctrl_reg[dlom_pkg::CTRL_MODE_LSB +: 3];
    assign aux_active = ctrl_reg[dlom_pkg::CTRL_AUX_EN] || mode == dlom_pkg::MODE_ARC;
    assign offset_blocked = aux_active && mode != dlom_pkg::MODE_ARC;
    assign pri_write  = wr_do && awaddr_reg == dlom_pkg::ADDR_PRI_CMD;

    // offset limited to one full output either way
    always_comb begin
        clamp_hit      = 1'b0;
        offset_clamped = offset_stage_reg[10:0];
        if (offset_stage_reg > 16'sh03ff) begin
            offset_clamped = dlom_pkg::FULL_OUT;
            clamp_hit      = 1'b1;
        end else if (offset_stage_reg < -16'sh03ff) begin
            offset_clamped = -dlom_pkg::FULL_OUT;
            clamp_hit      = 1'b1;
        end
    end

    // commands; the staged offset is consumed by the primary command write
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pri_cmd_reg      <= '0;
            aux_cmd_reg      <= '0;
            offset_stage_reg <= 16'sh0000;
            cmd_offset_reg   <= 11'sh000;
        end else if (wr_do) begin
            if (awaddr_reg == dlom_pkg::ADDR_PRI_CMD) begin
                pri_cmd_reg      <= merge(pri_cmd_reg, wdata_reg, wstrb_reg);
                cmd_offset_reg   <= offset_blocked ? 11'sh000 : offset_clamped;
                offset_stage_reg <= 16'sh0000;
            end else if (awaddr_reg == dlom_pkg::ADDR_AUX_CMD) begin
                aux_cmd_reg <= merge(aux_cmd_reg, wdata_reg, wstrb_reg);
            end else if (awaddr_reg == dlom_pkg::ADDR_OFFSET) begin
                offset_stage_reg <= 16'(merge({16'h0000, offset_stage_reg}, wdata_reg, wstrb_reg));
            end
        end
    end

    // sticky status, hardware set wins over write-one-to-clear
    always_comb begin
        sticky_next = sticky_reg;
        if (wr_do && awaddr_reg == dlom_pkg::ADDR_STATUS && wstrb_reg[0]) begin
            sticky_next = sticky_next & ~wdata_reg[1:0];
        end
        if (pri_write && offset_blocked && offset_stage_reg != 16'sh0000) begin
            sticky_next[dlom_pkg::STAT_DROP] = 1'b1;
        end
        if (pri_write && clamp_hit) begin
            sticky_next[dlom_pkg::STAT_CLAMP] = 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sticky_reg <= 2'h0;
        end else begin
            sticky_reg <= sticky_next;
        end
    end

    // read path
    always_comb begin
        rd_ok   = 1'b1;
        rd_word = 32'h0000_0000;
        case (s_axi_araddr)
            dlom_pkg::ADDR_CTRL:    rd_word = ctrl_reg;
            dlom_pkg::ADDR_PRI_CMD: rd_word = pri_cmd_reg;
            dlom_pkg::ADDR_AUX_CMD: rd_word = aux_cmd_reg;
            dlom_pkg::ADDR_OFFSET:  rd_word = {16'h0000, offset_stage_reg};
            dlom_pkg::ADDR_GAIN:    rd_word = {16'h0000, gain_reg};
            dlom_pkg::ADDR_OUTPUTS: begin
                rd_word[10:0] = motor_out;
                rd_word[dlom_pkg::OUT_FOLLOW_LSB +: 11] = follow_aux_difference;
            end
            dlom_pkg::ADDR_STATUS:  rd_word = {29'h0, aux_active, sticky_reg};
            default:                rd_ok   = 1'b0;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= dlom_pkg::RESP_OKAY;
        end else if (rd_do) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_word;
            s_axi_rresp   <= rd_ok ? dlom_pkg::RESP_OKAY : dlom_pkg::RESP_SLVERR;
        end else if (s_axi_rvalid) begin
            if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end else begin
            s_axi_arready <= 1'b1;
        end
    end

    // update sequencing: tick, loop calc, mix
    assign tick = upd_state_reg == UPD_IDLE && tick_cnt_reg == 32'(UPDATE_CYCLES - 1);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tick_cnt_reg  <= 32'h0;
            upd_state_reg <= UPD_IDLE;
        end else begin
            tick_cnt_reg <= tick ? 32'h0 : tick_cnt_reg + 32'h1;
            case (upd_state_reg)
                UPD_IDLE: upd_state_reg <= tick ? UPD_CALC : UPD_IDLE;
                UPD_CALC: upd_state_reg <= UPD_MIX;
                UPD_MIX:  upd_state_reg <= UPD_IDLE;
                default:  upd_state_reg <= UPD_IDLE;
            endcase
        end
    end

    // targets: both smoothed by the same profile in trapezoid mode
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pri_tgt_reg <= '0;
            aux_tgt_reg <= '0;
        end else if (tick) begin
            if (mode == dlom_pkg::MODE_TRAP) begin
                pri_tgt_reg <= smooth(pri_tgt_reg, pri_cmd_reg);
                aux_tgt_reg <= smooth(aux_tgt_reg, aux_cmd_reg);
            end else begin
                pri_tgt_reg <= pri_cmd_reg;
                aux_tgt_reg <= aux_cmd_reg;
            end
        end
    end

    // feedback forming
    assign pos_sum    = {left_pos[W-1], left_pos} + {right_pos[W-1], right_pos};
    assign vel_sum    = {left_vel[W-1], left_vel} + {right_vel[W-1], right_vel};
    assign pri_fb_raw = (mode == dlom_pkg::MODE_VELOCITY) ? vel_sum : pos_sum;
    assign pri_fb     = ctrl_reg[dlom_pkg::CTRL_AVG] ? $signed({pri_fb_raw[W], pri_fb_raw}) >>> 1
                                                     : $signed({pri_fb_raw[W], pri_fb_raw});
    // aux feedback uses positions in every mode; remote source set up by host
    assign aux_fb     = ctrl_reg[dlom_pkg::CTRL_AUX_REMOTE] ? {remote_heading[W-1], remote_heading}
                                                            : {left_pos[W-1], left_pos} - {right_pos[W-1], right_pos};
    assign aux_fb_x   = {aux_fb[W], aux_fb};
    assign pri_tgt_x  = {{2{pri_tgt_reg[W-1]}}, pri_tgt_reg};
    assign aux_tgt_x  = {{2{aux_tgt_reg[W-1]}}, aux_tgt_reg};

    dlom_pos_loop #(.IW(W + 2), .GW(8)) u_primary_loop (
        .clk      (clk),
        .rst      (rst),
        .calc     (upd_state_reg == UPD_CALC),
        .target   (pri_tgt_x),
        .feedback (pri_fb),
        .gain     (gain_reg[7:0]),
        .term     (pri_term)
    );

    dlom_pos_loop #(.IW(W + 2), .GW(8)) u_auxiliary_loop (
        .clk      (clk),
        .rst      (rst),
        .calc     (upd_state_reg == UPD_CALC),
        .target   (aux_tgt_x),
        .feedback (aux_fb_x),
        .gain     (gain_reg[dlom_pkg::GAIN_AUX_LSB +: 8]),
        .term     (aux_term)
    );

    // mixing
    assign pct_term   = sat13(13'(pri_cmd_reg));
    assign pri_use    = (mode == dlom_pkg::MODE_PERCENT) ? pct_term : pri_term;
    assign aux_eff    = !aux_active ? 13'sh0000
                      : ctrl_reg[dlom_pkg::CTRL_AUX_NEG] ? -13'(aux_term) : 13'(aux_term);
    assign off_eff    = offset_blocked ? 11'sh000 : cmd_offset_reg;
    assign motor_sum  = 13'(pri_use) + aux_eff + 13'(off_eff);
    assign follow_sum = 13'(pri_use) - aux_eff;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            motor_out             <= 11'sh000;
            follow_aux_difference <= 11'sh000;
            out_strobe            <= 1'b0;
        end else begin
            out_strobe <= upd_state_reg == UPD_MIX;
            if (upd_state_reg == UPD_MIX) begin
                motor_out             <= sat13(motor_sum);
                follow_aux_difference <= sat13(follow_sum);
            end
        end
    end

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    logic nosat;
    assign nosat = motor_sum == 13'(sat13(motor_sum)) && follow_sum == 13'(sat13(follow_sum));

    a_mix_sum_diff: assert property (upd_state_reg == UPD_MIX && nosat |=>
        13'(motor_out) + 13'(follow_aux_difference) == 13'($past(pri_use)) * 13'sd2 + 13'($past(off_eff)))
        else $error("sum of motor and follower outputs wrong");
    a_aux_sign_neg: assert property (upd_state_reg == UPD_MIX && nosat && aux_active
        && ctrl_reg[dlom_pkg::CTRL_AUX_NEG] |=> 13'(motor_out) - 13'(follow_aux_difference)
        == -13'sd2 * 13'($past(aux_term)) + 13'($past(off_eff)))
        else $error("inverted auxiliary sign not applied");
    a_out_range: assert property (motor_out <= dlom_pkg::FULL_OUT && motor_out >= -dlom_pkg::FULL_OUT
        && follow_aux_difference <= dlom_pkg::FULL_OUT && follow_aux_difference >= -dlom_pkg::FULL_OUT)
        else $error("output beyond full scale");
    a_offset_excl: assert property (upd_state_reg == UPD_MIX && offset_blocked && nosat |=>
        13'(motor_out) + 13'(follow_aux_difference) == 13'sd2 * 13'($past(pri_use)))
        else $error("offset applied with auxiliary loop");
    a_offset_consume: assert property (pri_write |=> offset_stage_reg == 16'sh0000)
        else $error("staged offset not consumed by command");
    a_offset_clamp: assert property (pri_write && !offset_blocked && offset_stage_reg > 16'sh03ff
        |=> cmd_offset_reg == dlom_pkg::FULL_OUT && sticky_reg[dlom_pkg::STAT_CLAMP])
        else $error("offset not clamped to full scale");
    a_update_seq: assert property (tick |=> upd_state_reg == UPD_CALC ##1 upd_state_reg == UPD_MIX ##1 out_strobe)
        else $error("update sequence broken");
    a_aux_pos_fb: assert property (mode == dlom_pkg::MODE_VELOCITY && !ctrl_reg[dlom_pkg::CTRL_AUX_REMOTE]
        |-> aux_fb == {left_pos[W-1], left_pos} - {right_pos[W-1], right_pos})
        else $error("auxiliary feedback not from positions");
    a_avg_fb: assert property (ctrl_reg[dlom_pkg::CTRL_AVG] && mode == dlom_pkg::MODE_POSITION
        |-> 36'(pri_fb) * 36'sd2 + $signed({35'h0, pos_sum[0]}) == 36'(pos_sum))
        else $error("average feedback wrong");
    a_arc_aux: assert property (mode == dlom_pkg::MODE_ARC |-> aux_active && !offset_blocked)
        else $error("arc mode lost auxiliary loop");
    a_trap_same: assert property (tick && mode == dlom_pkg::MODE_TRAP && pri_cmd_reg == pri_tgt_reg
        |=> pri_tgt_reg == $past(pri_cmd_reg))
        else $error("settled target moved");
    a_write_resp: assert property (wr_do |=> s_axi_bvalid)
        else $error("write response missing");

    c_aux_mix: cover property (upd_state_reg == UPD_MIX && aux_active ##1 out_strobe);
    c_offset_drop: cover property ($rose(sticky_reg[dlom_pkg::STAT_DROP]));
    c_arc_offset: cover property (mode == dlom_pkg::MODE_ARC && off_eff != 11'sh000 && out_strobe);
endmodule // dlom_mixer

/* design/dlom_pkg.sv */
// shared constants for the dual loop output mixer
package dlom_pkg;
    localparam logic [7:0]  ADDR_CTRL       = 8'h00;
    localparam logic [7:0]  ADDR_PRI_CMD    = 8'h04;
    localparam logic [7:0]  ADDR_AUX_CMD    = 8'h08;
    localparam logic [7:0]  ADDR_OFFSET     = 8'h0c;
    localparam logic [7:0]  ADDR_GAIN       = 8'h10;
    localparam logic [7:0]  ADDR_OUTPUTS    = 8'h14;
    localparam logic [7:0]  ADDR_STATUS     = 8'h18;
    localparam int          CTRL_AUX_EN     = 0;
    localparam int          CTRL_AUX_NEG    = 1;
    localparam int          CTRL_MODE_LSB   = 2;
    localparam int          CTRL_AVG        = 5;
    localparam int          CTRL_AUX_REMOTE = 6;
    localparam int          GAIN_AUX_LSB    = 8;
    localparam int          OUT_FOLLOW_LSB  = 16;
    localparam int          STAT_DROP       = 0;
    localparam int          STAT_CLAMP      = 1;
    localparam int          STAT_AUX_ACT    = 2;
    localparam logic [31:0] CTRL_RESET      = 32'h0000_0000;
    localparam logic [15:0] GAIN_RESET      = 16'h1010;
    localparam logic [2:0]  MODE_PERCENT    = 3'h0;
    localparam logic [2:0]  MODE_POSITION   = 3'h1;
    localparam logic [2:0]  MODE_VELOCITY   = 3'h2;
    localparam logic [2:0]  MODE_TRAP       = 3'h3;
    localparam logic [2:0]  MODE_ARC        = 3'h4;
    localparam int          TERM_W          = 11;
    localparam logic signed [10:0] FULL_OUT = 11'sh3ff;
    localparam int          KP_SHIFT        = 4;
    localparam int          SMOOTH_SHIFT    = 3;
    localparam int          CLK_PERIOD_PS   = 5000;
    localparam int          UPDATE_PERIOD_US = 1000;
    localparam int          UPDATE_CYCLES   = (UPDATE_PERIOD_US * 1000) / CLK_PERIOD_PS;
    localparam logic [1:0]  RESP_OKAY       = 2'h0;
    localparam logic [1:0]  RESP_SLVERR     = 2'h2;
endpackage

/* design/dlom_pos_loop.sv */
// proportional loop term, saturated to full output
`timescale 1ns/1ps
module dlom_pos_loop #(
    parameter int IW = 34,
    parameter int GW = 8
) (
    input  wire logic                 clk,
    input  wire logic                 rst,
    input  wire logic                 calc,
    input  wire logic signed [IW-1:0] target,
    input  wire logic signed [IW-1:0] feedback,
    input  wire logic [GW-1:0]        gain,
    output logic signed [10:0]        term
);
    logic signed [IW:0]      err_w;
    logic signed [IW+GW+1:0] prod;
    logic signed [IW+GW+1:0] scaled;

    assign err_w  = {target[IW-1], target} - {feedback[IW-1], feedback};
    assign prod   = err_w * $signed({1'b0, gain});
    assign scaled = prod >>> dlom_pkg::KP_SHIFT;

    // term held between updates, scale 1023 = full output
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            term <= 11'sh000;
        end else if (calc) begin
            if (scaled > dlom_pkg::FULL_OUT) begin
                term <= dlom_pkg::FULL_OUT;
            end else if (scaled < -dlom_pkg::FULL_OUT) begin
                term <= -dlom_pkg::FULL_OUT;
            end else begin
                term <= scaled[10:0];
            end
        end
    end
endmodule // dlom_pos_loop

/* tb/dlom_follower_model.sv */
// follower controller model that applies the difference demand
`timescale 1ns/1ps
module dlom_follower_model (
    input  wire logic               clk,
    input  wire logic               rst,
    input  wire logic               out_strobe,
    input  wire logic signed [10:0] follow_aux_difference,
    output logic signed [10:0]      applied
);
    always_ff @(posedge clk or posedge rst) begin
        if (rst) applied <= '0;
        else if (out_strobe) applied <= follow_aux_difference;
    end
endmodule // dlom_follower_model

/* tb/dual_loop_output_mixer_tb_top.sv */
// self-checking bench for the dual loop output mixer
`timescale 1ns/1ps
module dual_loop_output_mixer_tb_top;
    logic               clk, rst, awvalid, wvalid, bready, arvalid, rready;
    logic               awready, wready, bvalid, arready, rvalid, stb;
    logic [7:0]         awaddr, araddr;
    logic [31:0]        wdata, rdata, rd;
    logic [1:0]         bresp, rresp, rs;
    logic signed [31:0] lp, rp, lv, rv, hd;
    logic signed [10:0] mo, fo, fa, em, ef;
    int                 num_errors, checked, seed, i, md, en, ng, av, rm, pc, ac, of, a, f, x, o;
    dlom_mixer #(.UPDATE_CYCLES(8)) dut (.clk(clk), .rst(rst), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .left_pos(lp), .right_pos(rp), .left_vel(lv), .right_vel(rv), .remote_heading(hd),
        .motor_out(mo), .follow_aux_difference(fo), .out_strobe(stb));
    dlom_follower_model fm (.clk(clk), .rst(rst), .out_strobe(stb), .follow_aux_difference(fo), .applied(fa));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    function automatic logic signed [10:0] sat(input int v);
        return (v > 1023) ? 11'sh3ff : (v < -1023) ? -11'sh3ff : 11'(v);
    endfunction
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        checked++;
        if (s !== e) begin
            num_errors++;
            $display("BAD %s exp %h got %h", n, e, s);
        end
    endtask
    task automatic wr(input logic [7:0] ad, input int d);
        logic ta, tw;
        @(posedge clk);
        awaddr  <= ad;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        forever begin
            @(negedge clk);
            if (!awvalid && !wvalid && bvalid) break;
            ta = awready;
            tw = wready;
            @(posedge clk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
        end
        rs = bresp;
        @(posedge clk);
        bready <= 1'b0;
    endtask
    task automatic rr(input logic [7:0] ad);
        logic t;
        @(posedge clk);
        araddr  <= ad;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        forever begin
            @(negedge clk);
            if (!arvalid && rvalid) break;
            t = arready;
            @(posedge clk);
            if (t) arvalid <= 1'b0;
        end
        rd = rdata;
        rs = rresp;
        @(posedge clk);
        rready <= 1'b0;
    endtask
    task automatic end_of_test;
        $display("checks %0d errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    initial begin
        repeat (40000) @(posedge clk);
        num_errors++;
        end_of_test;
    end
    initial begin
        seed = 17;
        rst = 1'b1;
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wdata} = '0;
        {lp, rp, lv, rv, hd} = '0;
        {num_errors, checked} = '0;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        for (i = 0; i < 20; i++) begin
            md = i % 5;
            en = (i / 5) % 2;
            ng = (i / 10) % 2;
            rm = i / 15;
            av = $random(seed) & 1;
            pc = (i == 0) ? 1000 : $random(seed) % 400;
            ac = $random(seed) % 300;
            of = (i == 0) ? 2000 : $random(seed) % 200;
            @(posedge clk);
            lp <= $random(seed) % 500;
            rp <= $random(seed) % 500;
            lv <= $random(seed) % 300;
            rv <= $random(seed) % 300;
            hd <= $random(seed) % 300;
            wr(dlom_pkg::ADDR_CTRL, rm * 64 + av * 32 + md * 4 + ng * 2 + en);
            wr(dlom_pkg::ADDR_AUX_CMD, ac);
            wr(dlom_pkg::ADDR_OFFSET, of);
            wr(dlom_pkg::ADDR_PRI_CMD, pc);
            repeat (500) @(negedge clk);
            a = en | (md == 4);
            f = (md == 2) ? lv + rv : lp + rp;
            if (av) f = f >>> 1;
            x = a ? sat(ac - (rm ? hd : lp - rp)) : 0;
            if (ng) x = -x;
            o = (a && md != 4) ? 0 : sat(of);
            em = sat(sat(md == 0 ? pc : pc - f) + x + o);
            ef = sat(sat(md == 0 ? pc : pc - f) - x);
            chk("motor", em, mo);
            chk("follower", ef, fo);
            chk("model", ef, fa);
            rr(dlom_pkg::ADDR_OUTPUTS);
            chk("outputs", {5'h00, ef, 5'h00, em}, rd);
            rr(dlom_pkg::ADDR_STATUS);
            chk("dropped", a && md != 4 && of != 0, rd[0]);
            chk("clamped", of > 1023 || of < -1023, rd[1]);
            chk("aux active", a, rd[2]);
            wr(dlom_pkg::ADDR_STATUS, 3);
            chk("bresp", dlom_pkg::RESP_OKAY, rs);
            $display("test %0d done", i);
        end
        rr(8'h40);
        chk("unmapped", dlom_pkg::RESP_SLVERR, rs);
        wr(8'h40, 0);
        chk("unmapped write", dlom_pkg::RESP_SLVERR, rs);
        end_of_test;
    end
endmodule // dual_loop_output_mixer_tb_top
